// File: mst_ea_check.sv
// Effective address mode legality checks for the executor.
`timescale 1ns/10ps
module mst_ea_check (
   // Effective address field.
   input wire logic [2:0] ea_mode,
   input wire logic [2:0] ea_reg,
   // Legality results.
   output logic data_alt,
   output logic mem_alt,
   output logic any_src
);
   import mst_pkg::*;
   logic abs_ok;

   assign abs_ok = (ea_mode == MST_MODE_EXT) && (ea_reg[2:1] == 2'b00);
   assign data_alt = (ea_mode != MST_MODE_EXT) || abs_ok;
   assign mem_alt = ((ea_mode != MST_MODE_EXT) && (ea_mode[2:1] != 2'b00)) || abs_ok;
   assign any_src = (ea_mode != MST_MODE_EXT) || (ea_reg <= 3'h4);
endmodule : mst_ea_check

// File: mst_exec.sv
// Executor for quick move, extend moves, saturate, test-and-set and address moves.
//
// Local design decisions: the register offsets and the AXI4-Lite register port.
`timescale 1ns/10ps
module mst_exec #(
   parameter int ADDR_W = 12,
   parameter int CNT_W = 16
) (
   // Clock and reset.
   input wire logic clock,
   input wire logic sys_rst,
   // Instruction stream with resolved source operand and effective address.
   input wire logic instr_valid,
   output logic instr_ready,
   input wire logic [15:0] instr_word,
   input wire logic [31:0] src_value,
   input wire logic [31:0] ea_addr,
   output logic illegal_exc,
   // Register file.
   output logic [3:0] rf_rd_idx,
   input wire logic [31:0] rf_rd_data,
   output mst_pkg::mst_rf_wr_type rf_wr,
   // Condition code register.
   input wire logic [4:0] ccr_in,
   output logic ccr_we,
   output logic [4:0] ccr_out,
   // Data memory.
   output mst_pkg::mst_mem_req_type mem_req,
   input wire logic mem_ack,
   input wire logic [31:0] mem_rdata,
   // AXI4-Lite slave.
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   import mst_pkg::*;

   typedef struct packed {
      mst_state_type st;
      logic enable;
      logic illegal;
      logic ccr_we;
      logic [4:0] condition_code_reg;
      mst_rf_wr_type rf;
      mst_mem_req_type mem;
      logic [CNT_W-1:0] ret_cnt;
      logic [CNT_W-1:0] ill_cnt;
      logic aw_hold;
      logic [ADDR_W-1:0] aw_addr;
      logic w_hold;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
   } mst_core_type;

   mst_core_type q;
   mst_core_type d;
   logic take;
   logic is_quick;
   logic is_sext;
   logic is_zfil;
   logic is_signed_saturate;
   logic is_tas;
   logic is_move_to_address_reg;
   logic data_alt;
   logic mem_alt;
   logic any_src;
   logic [2:0] ea_mode;
   logic [31:0] quick_imm;
   logic [31:0] ext_res;
   logic [31:0] sat_res;
   logic [31:0] move_to_address_reg_res;
   logic [7:0] tas_byte;

   // Register select: 0 control, 1 status, 2 retired, 3 illegal, 4 unmapped.
   function automatic logic [2:0] mst_reg_sel(input logic [ADDR_W-1:0] a);
      logic [2:0] s;
      s = 3'h4;
      if (a == ADDR_W'(MST_CTRL_OFS)) s = 3'h0;
      if (a == ADDR_W'(MST_STATUS_OFS)) s = 3'h1;
      if (a == ADDR_W'(MST_RETIRED_OFS)) s = 3'h2;
      if (a == ADDR_W'(MST_ILLEGAL_OFS)) s = 3'h3;
      return s;
   endfunction : mst_reg_sel

   // Flags from a long result: N and Z from value, V and C cleared, X kept.
   function automatic logic [4:0] mst_flags(input logic [4:0] old, input logic [31:0] res);
      logic [4:0] f;
      f = '0;
      f[MST_CCR_X] = old[MST_CCR_X];
      f[MST_CCR_N] = res[31];
      f[MST_CCR_Z] = (res == 32'h00000000);
      return f;
   endfunction : mst_flags

   ////////////////////////////////////////////////////////////////////////////
   // Decode.
   assign ea_mode = instr_word[5:3];
   assign take = instr_valid && instr_ready;
   assign is_quick = (instr_word[15:12] == MST_QUICK_TOP) && (instr_word[8:6] == MST_QUICK_MID);
   assign is_sext = (instr_word[15:12] == MST_EXT_TOP) && (instr_word[8:7] == MST_SEXT_SEL);
   assign is_zfil = (instr_word[15:12] == MST_EXT_TOP) && (instr_word[8:7] == MST_ZFIL_SEL);
   assign is_signed_saturate = (instr_word[15:3] == MST_SIGNED_SATURATE_OP);
   assign is_tas = (instr_word[15:6] == MST_TAS_OP);
   assign is_move_to_address_reg = (instr_word[15:14] == MST_MOVE_TO_ADDRESS_REG_TOP) && (instr_word[13:13] == 1'b1)
      && (instr_word[8:6] == MST_MOVE_TO_ADDRESS_REG_MID);

   mst_ea_check u_ea (
      .ea_mode(ea_mode),
      .ea_reg(instr_word[2:0]),
      .data_alt(data_alt),
      .mem_alt(mem_alt),
      .any_src(any_src)
   );

   // Field zero stands for minus one.
   assign quick_imm = (instr_word[11:9] == 3'h0) ? MST_QUICK_M1 : {29'h0, instr_word[11:9]};
   // Size bit picks byte or word.
   always_comb begin
      if (instr_word[6] == 1'b0) begin
         ext_res = {{24{is_sext & src_value[7]}}, src_value[7:0]};
      end else begin
         ext_res = {{16{is_sext & src_value[15]}}, src_value[15:0]};
      end
   end
   // Saturate by the sign only when overflow is set.
   assign sat_res = !ccr_in[MST_CCR_V] ? rf_rd_data : (rf_rd_data[31] ? MST_SAT_POS : MST_SAT_NEG);
   assign move_to_address_reg_res = (instr_word[13:12] == MST_MOVE_TO_ADDRESS_REG_WORD) ? {{16{src_value[15]}}, src_value[15:0]}
      : src_value;
   assign tas_byte = mem_rdata[7:0];

   ////////////////////////////////////////////////////////////////////////////
   // Execution and register bus.
   always_comb begin
      d = q;
      d.illegal = 1'b0;
      d.ccr_we = 1'b0;
      d.rf.we = 1'b0;
      unique case (q.st)
         MST_IDLE: begin
            if (take) begin
               d.ret_cnt = q.ret_cnt + 1'b1;
               if (is_quick && data_alt) begin
                  d.condition_code_reg = mst_flags(ccr_in, quick_imm);
                  d.ccr_we = 1'b1;
                  if (ea_mode == MST_MODE_DREG || ea_mode == MST_MODE_AREG) begin
                     d.rf = '{we: 1'b1, idx: {ea_mode[0], instr_word[2:0]}, data: quick_imm};
                  end else begin
                     d.mem = '{req: 1'b1, we: 1'b1, lock: 1'b0, byte_sz: 1'b0, addr: ea_addr, wdata: quick_imm};
                     d.ret_cnt = q.ret_cnt;
                     d.st = MST_MEMWR;
                  end
               end else if ((is_sext || is_zfil) && any_src) begin
                  d.rf = '{we: 1'b1, idx: {1'b0, instr_word[11:9]}, data: ext_res};
                  d.condition_code_reg = mst_flags(ccr_in, ext_res);
                  d.condition_code_reg[MST_CCR_N] = is_sext & ext_res[31];
                  d.ccr_we = 1'b1;
               end else if (is_signed_saturate) begin
                  d.rf = '{we: ccr_in[MST_CCR_V], idx: {1'b0, instr_word[2:0]}, data: sat_res};
                  d.condition_code_reg = mst_flags(ccr_in, sat_res);
                  d.ccr_we = 1'b1;
               end else if (is_tas && mem_alt) begin
                  d.mem = '{req: 1'b1, we: 1'b0, lock: 1'b1, byte_sz: 1'b1, addr: ea_addr, wdata: 32'h00000000};
                  d.ret_cnt = q.ret_cnt;
                  d.st = MST_TAS_RD;
               end else if (is_move_to_address_reg && any_src) begin
                  d.rf = '{we: 1'b1, idx: {1'b1, instr_word[11:9]}, data: move_to_address_reg_res};
               end else begin
                  d.illegal = 1'b1;
                  d.ret_cnt = q.ret_cnt;
                  d.ill_cnt = q.ill_cnt + 1'b1;
               end
            end
         end
         MST_MEMWR: begin
            if (mem_ack) begin
               d.mem.req = 1'b0;
               d.ret_cnt = q.ret_cnt + 1'b1;
               d.st = MST_IDLE;
            end
         end
         MST_TAS_RD: begin
            if (mem_ack) begin
               d.condition_code_reg = mst_flags(ccr_in, {tas_byte, 24'h000000});
               d.ccr_we = 1'b1;
               // Write back with bit 7 set.
               d.mem.we = 1'b1;
               d.mem.wdata = {24'h000000, tas_byte | MST_TAS_SET};
               d.st = MST_TAS_WR;
            end
         end
         MST_TAS_WR: begin
            if (mem_ack) begin
               d.mem.req = 1'b0;
               d.mem.lock = 1'b0;
               d.ret_cnt = q.ret_cnt + 1'b1;
               d.st = MST_IDLE;
            end
         end
      endcase

      if (s_axi_awvalid && !q.aw_hold) begin
         d.aw_hold = 1'b1;
         d.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !q.w_hold) begin
         d.w_hold = 1'b1;
         d.wdata = s_axi_wdata;
         d.wstrb = s_axi_wstrb;
      end
      if (q.bvalid && s_axi_bready) begin
         d.bvalid = 1'b0;
      end
      if (q.aw_hold && q.w_hold && !q.bvalid) begin
         d.aw_hold = 1'b0;
         d.w_hold = 1'b0;
         d.bvalid = 1'b1;
         d.bresp = (mst_reg_sel(q.aw_addr) == 3'h4) ? MST_RESP_SLVERR : MST_RESP_OKAY;
         if (mst_reg_sel(q.aw_addr) == 3'h0 && q.wstrb[0]) begin
            d.enable = q.wdata[MST_CTRL_EN_BIT];
         end
      end
      if (q.rvalid && s_axi_rready) begin
         d.rvalid = 1'b0;
      end
      if (s_axi_arvalid && !q.rvalid) begin
         d.rvalid = 1'b1;
         d.rresp = MST_RESP_OKAY;
         d.rdata = 32'h00000000;
         case (mst_reg_sel(s_axi_araddr))
            3'h0: d.rdata[MST_CTRL_EN_BIT] = q.enable;
            3'h1: begin
               d.rdata[MST_STAT_BUSY_BIT] = (q.st != MST_IDLE);
               d.rdata[MST_STAT_LOCK_BIT] = q.mem.lock;
               d.rdata[MST_STAT_CCR_LSB +: 5] = ccr_in;
            end
            3'h2: d.rdata = {{(32-CNT_W){1'b0}}, q.ret_cnt};
            3'h3: d.rdata = {{(32-CNT_W){1'b0}}, q.ill_cnt};
            default: d.rresp = MST_RESP_SLVERR;
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         q <= '0;
         q.st <= MST_IDLE;
         q.enable <= MST_ENABLE_RST;
      end else begin
         q <= d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs.
   assign instr_ready = (q.st == MST_IDLE) && q.enable;
   assign illegal_exc = q.illegal;
   assign rf_rd_idx = {1'b0, instr_word[2:0]};
   assign rf_wr = q.rf;
   assign ccr_we = q.ccr_we;
   assign ccr_out = q.condition_code_reg;
   assign mem_req = q.mem;
   assign s_axi_awready = !q.aw_hold;
   assign s_axi_wready = !q.w_hold;
   assign s_axi_bvalid = q.bvalid;
   assign s_axi_bresp = q.bresp;
   assign s_axi_arready = !q.rvalid;
   assign s_axi_rvalid = q.rvalid;
   assign s_axi_rresp = q.rresp;
   assign s_axi_rdata = q.rdata;

   ////////////////////////////////////////////////////////////////////////////
   // Checks.
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (sys_rst);

   sequence s_tas_start;
      take && is_tas && mem_alt;
   endsequence
   sequence s_tas_read_done;
      mem_req.req && !mem_req.we && mem_req.lock && mem_ack;
   endsequence

   a_quick_imm_range: assert property (
      take && is_quick && ea_mode == MST_MODE_DREG |=> rf_wr.we
      && (rf_wr.data == MST_QUICK_M1 || (rf_wr.data >= 32'h1 && rf_wr.data <= 32'h7)))
      else $error("quick move value out of range");
   a_quick_zero_field: assert property (
      take && is_quick && instr_word[11:9] == 3'h0 && ea_mode == MST_MODE_DREG
      |=> rf_wr.data == MST_QUICK_M1)
      else $error("quick field zero not minus one");
   a_quick_mem_long: assert property (
      take && is_quick && data_alt && ea_mode[2:1] != 2'b00
      |=> mem_req.req && mem_req.we && !mem_req.byte_sz && mem_req.wdata == $past(quick_imm))
      else $error("quick store not a full long");
   a_quick_flags: assert property (
      take && is_quick && data_alt |=> ccr_we && !ccr_out[MST_CCR_V] && !ccr_out[MST_CCR_C]
      && ccr_out[MST_CCR_X] == $past(ccr_in[MST_CCR_X]))
      else $error("quick move flags wrong");
   a_sext_byte: assert property (
      take && is_sext && any_src && !instr_word[6]
      |=> rf_wr.we && rf_wr.data[31:8] == {24{rf_wr.data[7]}} && rf_wr.data[7:0] == $past(src_value[7:0]))
      else $error("byte sign extension wrong");
   a_zfil_word: assert property (
      take && is_zfil && any_src && instr_word[6] |=> rf_wr.data[31:16] == 16'h0000
      && rf_wr.data[15:0] == $past(src_value[15:0]) && !ccr_out[MST_CCR_N])
      else $error("word zero fill wrong");
   a_signed_saturate_value: assert property (
      take && is_signed_saturate |=> rf_wr.we == $past(ccr_in[MST_CCR_V])
      && (!rf_wr.we || rf_wr.data[31] != $past(rf_rd_data[31])))
      else $error("saturate result wrong");
   a_tas_read_lock: assert property (
      s_tas_start |=> mem_req.req && !mem_req.we && mem_req.lock && mem_req.byte_sz)
      else $error("test-and-set read not locked");
   a_tas_write_back: assert property (
      s_tas_read_done |=> mem_req.req && mem_req.we && mem_req.lock && mem_req.wdata[7])
      else $error("test-and-set write lacks bit 7");
   a_tas_flag_byte: assert property (
      s_tas_read_done |=> ccr_we && ccr_out[MST_CCR_N] == $past(mem_rdata[7])
      && ccr_out[MST_CCR_Z] == ($past(mem_rdata[7:0]) == 8'h00))
      else $error("test-and-set flags not from byte");
   a_tas_lock_hold: assert property (
      q.st == MST_TAS_RD || q.st == MST_TAS_WR |-> mem_req.lock && mem_req.req && !instr_ready)
      else $error("test-and-set cycle not locked");
   a_bad_mode_trap: assert property (
      take && is_tas && !mem_alt |=> illegal_exc && !mem_req.req && !rf_wr.we)
      else $error("bad mode not trapped");
   a_move_to_address_reg_no_flags: assert property (
      take && is_move_to_address_reg && any_src |=> !ccr_we && rf_wr.idx[3])
      else $error("address move touched flags");
endmodule : mst_exec

// File: mst_exec_test.sv
// Self-checking testbench for the move, saturate and test-and-set executor.
`timescale 1ns/10ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin err_total++; \
   $display("unexpected at %0t: got %h exp %h", $time, (g), (e)); end end
module mst_exec_test;
   import mst_pkg::*;
   logic clock = 1'b0;
   logic sys_rst = 1'b1;
   logic instr_valid = 1'b0;
   logic [15:0] instr_word = 16'h0;
   logic [31:0] src_value = 32'h0;
   logic [31:0] ea_addr = 32'h0;
   logic [4:0] ccr_in = 5'h0;
   logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
   logic [31:0] s_axi_wdata = 32'h0;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic instr_ready, illegal_exc, ccr_we, mem_ack, s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic s_axi_arready, s_axi_rvalid;
   logic [3:0] rf_rd_idx;
   logic [4:0] ccr_out;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] rf_rd_data, mem_rdata, s_axi_rdata, v, s;
   logic [31:0] rfile [0:7];
   logic [43:0] ev, got;
   logic [7:0] b;
   logic [4:0] c;
   mst_rf_wr_type rf_wr;
   mst_mem_req_type mem_req;
   logic [43:0] exp_q [$];
   int err_total = 0, compares = 0, ill_cnt = 0, ret_total = 0;
   logic [5:0] ext_ea [12] = '{6'h00, 6'h09, 6'h12, 6'h1B, 6'h24, 6'h2D, 6'h36, 6'h38, 6'h39, 6'h3C, 6'h3A, 6'h3B};
   logic [5:0] tas_ea [7] = '{6'h10, 6'h18, 6'h20, 6'h28, 6'h30, 6'h38, 6'h39};
   logic [15:0] bad_op [5] = '{16'h4AC0, 16'h4AC8, 16'h4AFC, 16'h4AFA, 16'hFFFF};
   logic [31:0] sat_tab [4] = '{32'h92345678, 32'h0, 32'h5, 32'h80000001};

   always #20 clock = ~clock;
   assign rf_rd_data = rfile[rf_rd_idx[2:0]];

   mst_exec #(.ADDR_W(12), .CNT_W(16)) mst_exec_inst (.clock(clock), .sys_rst(sys_rst),
      .instr_valid(instr_valid), .instr_ready(instr_ready), .instr_word(instr_word), .src_value(src_value),
      .ea_addr(ea_addr), .illegal_exc(illegal_exc), .rf_rd_idx(rf_rd_idx), .rf_rd_data(rf_rd_data),
      .rf_wr(rf_wr), .ccr_in(ccr_in), .ccr_we(ccr_we), .ccr_out(ccr_out), .mem_req(mem_req),
      .mem_ack(mem_ack), .mem_rdata(mem_rdata), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

   mst_mem_model mst_mem_model_inst (.clock(clock), .sys_rst(sys_rst), .mem_req(mem_req), .mem_ack(mem_ack),
      .mem_rdata(mem_rdata));

   function automatic logic [43:0] mk(logic we, logic [3:0] i, logic [31:0] d, logic cw, logic [4:0] f, logic il);
      return {we, we ? {i, d} : 36'h0, cw, cw ? f : 5'h0, il};
   endfunction : mk

   function automatic logic [4:0] fl(logic x, logic [31:0] r);
      return {x, r[31], r == 32'h0, 2'b00};
   endfunction : fl

   task automatic end_of_test();
      if (err_total == 0 && compares > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : end_of_test

   task automatic guard(input int n);
      if (n >= 100) begin
         err_total++;
         end_of_test();
      end
   endtask : guard

   ////////////////////////////////////////////////////////////////////////////////
   // Offers one instruction and leaves valid high so the next one can follow at once.
   task automatic issue(input logic [15:0] w, input logic [31:0] sv, input logic [31:0] a,
                        input logic [4:0] f, input logic [43:0] e);
      int n;
      n = 0;
      exp_q.push_back(e);
      if (e[0]) ill_cnt++;
      else ret_total++;
      instr_valid <= 1'b1;
      instr_word <= w;
      src_value <= sv;
      ea_addr <= a;
      ccr_in <= f;
      do begin
         @(posedge clock);
         n++;
      end while (instr_ready !== 1'b1 && n < 100);
      guard(n);
   endtask : issue

   task automatic idle_drain();
      int n;
      n = 0;
      instr_valid <= 1'b0;
      do begin
         @(posedge clock);
         n++;
      end while ((instr_ready !== 1'b1 || exp_q.size() != 0 || mem_req.req !== 1'b0) && n < 100);
      guard(n);
   endtask : idle_drain

   task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
      int n;
      n = 0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge clock);
         n++;
         if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1 && n < 100);
      s_axi_bready <= 1'b0;
      `CHK(s_axi_bresp, r)
      guard(n);
      @(posedge clock);
   endtask : axi_wr

   task automatic axi_rd(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
      int n;
      n = 0;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge clock);
         n++;
         if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1 && n < 100);
      s_axi_rready <= 1'b0;
      `CHK(s_axi_rresp, r)
      if (r === MST_RESP_OKAY) `CHK(s_axi_rdata, d)
      guard(n);
      @(posedge clock);
   endtask : axi_rd

   ////////////////////////////////////////////////////////////////////////////////
   // Takes the oldest expectation whenever a register, flag or exception result appears.
   always @(posedge clock) begin
      got = mk(rf_wr.we, rf_wr.idx, rf_wr.data, ccr_we, ccr_out, illegal_exc);
      if (!sys_rst && (rf_wr.we === 1'b1 || ccr_we === 1'b1 || illegal_exc === 1'b1)) begin
         ev = (exp_q.size() != 0) ? exp_q.pop_front() : 44'h0;
         `CHK(got, ev)
      end
      if (mem_ack === 1'b1 && mem_req.byte_sz === 1'b1) `CHK(mem_req.lock, 1'b1)
   end

   initial begin
      for (int i = 0; i < 8; i++) rfile[i] = 32'h0;
      void'($urandom(54));
      repeat (8) @(posedge clock);
      sys_rst <= 1'b0;
      for (int i = 0; i < 8; i++) begin
         v = (i == 0) ? MST_QUICK_M1 : 32'(i);
         c = 5'($urandom);
         issue(16'hA140 | 16'(i << 9) | 16'((i & 1) << 3) | 16'(i), 32'h0, 32'h0, c,
               mk(1'b1, {i[0], i[2:0]}, v, 1'b1, fl(c[4], v), 1'b0));
      end
      for (int r = 2; r < 8; r++) issue(16'hA378 | 16'(r), 32'h0, 32'h0, 5'h0, mk(0, 0, 0, 0, 0, 1));
      for (int i = 0; i < 24; i++) begin
         s = $urandom;
         if (i % 5 == 0) s = s & 32'hFFFF0000;
         v = i[1] ? (i[0] ? {16'h0, s[15:0]} : {{16{s[15]}}, s[15:0]})
                  : (i[0] ? {24'h0, s[7:0]} : {{24{s[7]}}, s[7:0]});
         c = 5'($urandom);
         issue(16'h7100 | 16'(i[2:0]) << 9 | 16'(i[0]) << 7 | 16'(i[1]) << 6 | 16'(ext_ea[i % 12]), s, 32'h0, c,
               mk(1'b1, {1'b0, i[2:0]}, v, 1'b1, fl(c[4], v), 1'b0));
      end
      for (int k = 0; k < 4; k++) begin
         rfile[k + 1] = sat_tab[k];
         v = k[1] ? (sat_tab[k][31] ? MST_SAT_POS : MST_SAT_NEG) : sat_tab[k];
         c = {3'($urandom), k[1], 1'($urandom)};
         issue(16'h4C80 | 16'(k + 1), 32'h0, 32'h0, c,
               mk(k[1], 4'(k + 1), v, 1'b1, fl(c[4], v), 1'b0));
      end
      issue(16'h3440, 32'h12348765, 32'h0, 5'h0A, mk(1'b1, 4'hA, 32'hFFFF8765, 0, 0, 0));
      issue(16'h2640, 32'h82345678, 32'h0, 5'h15, mk(1'b1, 4'hB, 32'h82345678, 0, 0, 0));
      c = 5'h1F;
      issue(16'hA750, 32'h0, 32'h20, c, mk(0, 0, 0, 1, fl(c[4], 32'h3), 0));
      idle_drain();
      `CHK(mst_mem_model_inst.mem[8], 32'h3)
      for (int k = 0; k < 7; k++) begin
         b = (k == 0) ? 8'h00 : (k == 1) ? MST_TAS_SET : 8'($urandom);
         s = {24'($urandom), b};
         mst_mem_model_inst.mem[k] = s;
         c = 5'($urandom);
         issue(16'h4AC0 | 16'(tas_ea[k]), 32'h0, 32'(k * 4), c,
               mk(0, 0, 0, 1, {c[4], b[7], b == 8'h0, 2'b00}, 0));
         idle_drain();
         `CHK(mst_mem_model_inst.mem[k], {s[31:8], b | MST_TAS_SET})
      end
      for (int k = 0; k < 5; k++) issue(bad_op[k], 32'h0, 32'h0, 5'h0, mk(0, 0, 0, 0, 0, 1));
      idle_drain();
      axi_wr(MST_CTRL_OFS, 32'h0, MST_RESP_OKAY);
      instr_word <= 16'h4C81;
      instr_valid <= 1'b1;
      repeat (4) @(posedge clock);
      `CHK(instr_ready, 1'b0)
      instr_valid <= 1'b0;
      ccr_in <= 5'h15;
      axi_rd(MST_CTRL_OFS, 32'h0, MST_RESP_OKAY);
      axi_wr(MST_CTRL_OFS, 32'h1, MST_RESP_OKAY);
      `CHK(instr_ready, 1'b1)
      axi_rd(MST_RETIRED_OFS, 32'(ret_total), MST_RESP_OKAY);
      axi_rd(MST_STATUS_OFS, 32'(ccr_in) << MST_STAT_CCR_LSB, MST_RESP_OKAY);
      axi_rd(MST_ILLEGAL_OFS, 32'(ill_cnt), MST_RESP_OKAY);
      axi_wr(MST_ILLEGAL_OFS, 32'h55, MST_RESP_OKAY);
      axi_rd(MST_ILLEGAL_OFS, 32'(ill_cnt), MST_RESP_OKAY);
      axi_wr(12'h010, 32'h1, MST_RESP_SLVERR);
      axi_rd(12'h010, 32'h0, MST_RESP_SLVERR);
      end_of_test();
   end
endmodule : mst_exec_test

// File: mst_mem_model.sv
// Data memory model that answers byte and long transfers after a random stall.
`timescale 1ns/10ps
module mst_mem_model (
   // Clock and reset.
   input wire logic clock,
   input wire logic sys_rst,
   // Transfer request and answer.
   input wire mst_pkg::mst_mem_req_type mem_req,
   output logic mem_ack,
   output logic [31:0] mem_rdata
);
   import mst_pkg::*;
   logic [31:0] mem [0:15];
   logic [1:0] stall_q;

   initial begin
      for (int i = 0; i < 16; i++) begin
         mem[i] = 32'h0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Read data toggles outside an answer so that a stale value never looks valid.
   always @(posedge clock) begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (sys_rst) begin
         mem_rdata <= 32'h0;
         stall_q <= 2'h0;
      end else if (mem_req.req && !mem_ack) begin
         if (stall_q != 2'h0) begin
            stall_q <= stall_q - 2'h1;
         end else begin
            mem_ack <= 1'b1;
            stall_q <= 2'($urandom_range(3));
            if (!mem_req.we) begin
               mem_rdata <= mem[mem_req.addr[5:2]];
            end else if (mem_req.byte_sz) begin
               mem[mem_req.addr[5:2]][7:0] <= mem_req.wdata[7:0];
            end else begin
               mem[mem_req.addr[5:2]] <= mem_req.wdata;
            end
         end
      end
   end
endmodule : mst_mem_model

// File: mst_pkg.sv
// Package with constants and types for the move, saturate and test-and-set executor.
// How it works
// - Quick move immediate -1 to 7, long only.
// - Quick field 0 means -1, else itself.
// - Quick immediate written as full 32-bit long.
// - Quick move sets N,Z, clears V,C.
// - Quick destination modes 000-110, 111/000-001.
// - Byte sign extend copies bit 7 up.
// - Word sign extend copies bit 15 up.
// - Size bit 0 byte, 1 word.
// - Extend moves accept all twelve source modes.
// - Byte zero fill clears bits 31-8.
// - Word zero fill clears bits 31-16.
// - Zero fill clears N,V,C, sets Z from the result.
// - Saturate only when V set, by sign.
// - Saturate sets flags from long result.
// - Test-and-set flags from original byte.
// - Test-and-set writes byte with bit 7 set.
// - Test-and-set read and write stay locked.
// - Test-and-set modes 010-110, 111/000-001.
// - Address register move leaves flags alone.
package mst_pkg;
   localparam logic [11:0] MST_CTRL_OFS = 12'h000;
   localparam logic [11:0] MST_STATUS_OFS = 12'h004;
   localparam logic [11:0] MST_RETIRED_OFS = 12'h008;
   localparam logic [11:0] MST_ILLEGAL_OFS = 12'h00C;
   localparam int MST_CTRL_EN_BIT = 0;
   localparam int MST_STAT_BUSY_BIT = 0;
   localparam int MST_STAT_LOCK_BIT = 1;
   localparam int MST_STAT_CCR_LSB = 8;
   localparam logic MST_ENABLE_RST = 1'b1;
   localparam int MST_CCR_X = 4;
   localparam int MST_CCR_N = 3;
   localparam int MST_CCR_Z = 2;
   localparam int MST_CCR_V = 1;
   localparam int MST_CCR_C = 0;
   localparam logic [12:0] MST_SIGNED_SATURATE_OP = 13'h0990;
   localparam logic [9:0] MST_TAS_OP = 10'h12B;
   localparam logic [3:0] MST_QUICK_TOP = 4'hA;
   localparam logic [2:0] MST_QUICK_MID = 3'h5;
   localparam logic [3:0] MST_EXT_TOP = 4'h7;
   localparam logic [1:0] MST_SEXT_SEL = 2'h2;
   localparam logic [1:0] MST_ZFIL_SEL = 2'h3;
   localparam logic [1:0] MST_MOVE_TO_ADDRESS_REG_TOP = 2'h0;
   localparam logic [2:0] MST_MOVE_TO_ADDRESS_REG_MID = 3'h1;
   localparam logic [1:0] MST_MOVE_TO_ADDRESS_REG_LONG = 2'h2;
   localparam logic [1:0] MST_MOVE_TO_ADDRESS_REG_WORD = 2'h3;
   localparam logic [2:0] MST_MODE_DREG = 3'h0;
   localparam logic [2:0] MST_MODE_AREG = 3'h1;
   localparam logic [2:0] MST_MODE_EXT = 3'h7;
   localparam logic [31:0] MST_SAT_NEG = 32'h80000000;
   localparam logic [31:0] MST_SAT_POS = 32'h7FFFFFFF;
   localparam logic [31:0] MST_QUICK_M1 = 32'hFFFFFFFF;
   localparam logic [7:0] MST_TAS_SET = 8'h80;
   localparam logic [1:0] MST_RESP_OKAY = 2'h0;
   localparam logic [1:0] MST_RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      MST_IDLE = 2'b00,
      MST_MEMWR = 2'b01,
      MST_TAS_RD = 2'b10,
      MST_TAS_WR = 2'b11
   } mst_state_type;

   typedef struct packed {
      logic we;
      logic [3:0] idx;
      logic [31:0] data;
   } mst_rf_wr_type;

   typedef struct packed {
      logic req;
      logic we;
      logic lock;
      logic byte_sz;
      logic [31:0] addr;
      logic [31:0] wdata;
   } mst_mem_req_type;
endpackage : mst_pkg
